/* hdl/serial_spi_port.sv */
`timescale 1ns/1ps
module serial_spi_port
(
  // Clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  // Configuration options
  input  wire logic                 opt_serial_function,
  input  wire logic                 opt_select_bit,
  input  wire logic                 opt_collision_bit,
  // Register port
  input  wire serial_pkg::reg_req_s req,
  output logic [7:0]                rdata,
  // Serial pins
  input  wire serial_pkg::pins_in_s pins_i,
  output serial_pkg::pins_out_s     pins_o,
  // Status to the rest of the chip
  output logic                      twowire_selected,
  output logic [2:0]                periph_prescale
);
  import serial_pkg::*;

  // ----------------------------------------
  // Registers and decoded fields
  // ----------------------------------------
  logic [7:0]   ctl0;                  // First control
  logic [7:0]   ctl1;                  // Second control, two-wire only
  logic [7:2]   ctl2;                  // Third control, stored part
  logic [7:0]   serial_shift_data;     // Data and shift register
  logic         transfer_done_flag;    // Sticky done
  logic         write_collision_flag;  // Sticky collision
  serial_mode_e serial_mode_select;
  logic         serial_unit_on;
  logic         clock_idle_polarity;
  logic         clock_active_edge;
  logic         bit_order_select;
  logic         select_pin_enable;

  assign serial_mode_select  = serial_mode_e'(ctl0[CTL0_MODE_LSB +: 3]);
  assign serial_unit_on      = ctl0[CTL0_ON_BIT];
  assign clock_idle_polarity = ctl2[CTL2_POL_BIT];
  assign clock_active_edge   = ctl2[CTL2_EDGE_BIT];
  assign bit_order_select    = ctl2[CTL2_MLS_BIT];
  assign select_pin_enable   = ctl2[CTL2_SELECT_PIN_ENABLE_BIT];

  // ----------------------------------------
  // Operating conditions
  // ----------------------------------------
  logic is_master;      // One of the master rates
  logic is_slave;       // Slave mode
  logic engine_on;      // SPI logic live
  logic select_active;  // Select pin has its SPI role
  logic idle_lvl;       // Clock base level
  logic active_rising;  // Active edge is rising

  assign is_master = serial_mode_select inside
    {MODE_DIV4, MODE_DIV16, MODE_DIV64, MODE_DIV1, MODE_DIV2};
  assign is_slave  = (serial_mode_select == MODE_SLAVE);
  // Option, unit on and an SPI mode must all hold
  assign engine_on = opt_serial_function && serial_unit_on && (is_master || is_slave);
  assign select_active = engine_on && opt_select_bit && select_pin_enable;
  assign idle_lvl      = !clock_idle_polarity;
  assign active_rising = (clock_idle_polarity == clock_active_edge);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic sdi_m, sdi_s;         // Data in, two stages
  logic sck_m, sck_s, sck_d;  // Clock in, two stages and a delay
  logic scs_m, scs_s;         // Select in, two stages

  // Pins are asynchronous to clk_sys
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      sdi_m <= 1'b0;
      sdi_s <= 1'b0;
      sck_m <= 1'b0;
      sck_s <= 1'b0;
      sck_d <= 1'b0;
      scs_m <= 1'b1;
      scs_s <= 1'b1;
    end
    else
    begin
      sdi_m <= pins_i.sdi;
      sdi_s <= sdi_m;
      sck_m <= pins_i.sck;
      sck_s <= sck_m;
      sck_d <= sck_s;
      scs_m <= pins_i.scs_n;
      scs_s <= scs_m;
    end
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  logic wr_data, wr_ctl0, wr_ctl1, wr_ctl2;

  assign wr_data = req.wr && (req.addr == OFS_DATA);
  assign wr_ctl0 = req.wr && (req.addr == OFS_CTL0);
  assign wr_ctl1 = req.wr && (req.addr == OFS_CTL1);
  assign wr_ctl2 = req.wr && (req.addr == OFS_CTL2);

  // ----------------------------------------
  // Shift engine events
  // ----------------------------------------
  link_state_e state;      // Master sequencer
  logic        sck_q;      // Master clock level
  logic        sdo_q;      // Outgoing bit
  logic [3:0]  bitcnt;     // Active edges so far
  logic [3:0]  cnt_next;   // Count after this cycle's edge
  logic        div_tick;   // Half-period enable
  logic        slave_sel;  // Slave is selected
  logic        edge_ev;    // Any clock edge
  logic        edge_rise;  // That edge rises
  logic        edge_act;   // Active edge, sample
  logic        edge_inact; // Other edge, drive next bit
  logic        done_pulse; // Byte complete
  logic        busy;       // Transfer in progress
  logic        load_ok;    // Data write accepted
  logic        sel_hold;   // Select kept one cycle past the last edge

  // Deselected slave sees no clock
  assign slave_sel = is_slave && engine_on && (!select_active || !scs_s);

  always_comb
  begin
    edge_ev   = 1'b0;
    edge_rise = 1'b0;
    if (is_master && engine_on && state == ST_RUN)
    begin
      edge_ev   = div_tick;
      edge_rise = !sck_q;
    end
    else if (slave_sel)
    begin
      edge_ev   = (sck_s != sck_d);
      edge_rise = sck_s;
    end
  end

  assign edge_act   = edge_ev && (edge_rise == active_rising);
  assign edge_inact = edge_ev && (edge_rise != active_rising);
  assign cnt_next   = bitcnt + {3'b000, edge_act};
  // Master finishes once clock is back at its base level
  assign done_pulse = (cnt_next == BYTE_BITS) &&
    (is_master ? (edge_ev && edge_rise == idle_lvl) : edge_act);
  assign busy    = is_master ? (state == ST_RUN) : (bitcnt != 4'h0 || edge_ev);
  assign load_ok = wr_data && !busy;

  function automatic logic out_bit(input logic [7:0] v, input logic msb);
    return msb ? v[7] : v[0];
  endfunction

  // ----------------------------------------
  // Rate divider
  // ----------------------------------------
  serial_rate_divider u_div
  (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .run         (is_master && engine_on && state == ST_RUN),
    .half_cycles (half_period(serial_mode_select)),
    .tick        (div_tick)
  );

  // ----------------------------------------
  // Master sequencer
  // ----------------------------------------
  // A data write while idle starts the byte
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      state <= ST_IDLE;
    else if (!(is_master && engine_on))
      state <= ST_IDLE;
    else
    begin
      unique case (state)
        ST_IDLE: if (load_ok) state <= ST_RUN;
        ST_RUN:  if (done_pulse) state <= ST_IDLE;
      endcase
    end
  end

  // Master clock toggles per tick, rests at base level otherwise
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      sck_q <= SCK_IDLE_RESET;
    else if (!(is_master && engine_on) || state == ST_IDLE)
      sck_q <= idle_lvl;
    else if (div_tick)
      sck_q <= !sck_q;
  end

  // ----------------------------------------
  // Bit counter and shift data
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      bitcnt <= 4'h0;
    else if (!engine_on || (is_slave && !slave_sel) || done_pulse)
      bitcnt <= 4'h0;
    else if (edge_act)
      bitcnt <= cnt_next;
  end

  // Same register carries outgoing and incoming byte
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      serial_shift_data <= DATA_RESET;
    else if (load_ok)
      serial_shift_data <= req.wdata;
    else if (edge_act && bit_order_select)
      serial_shift_data <= {serial_shift_data[6:0], sdi_s};
    else if (edge_act)
      serial_shift_data <= {sdi_s, serial_shift_data[7:1]};
  end

  // Between bytes the output follows the loaded byte's first bit
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      sdo_q <= 1'b0;
    else if (edge_inact && bitcnt != 4'h0)
      sdo_q <= out_bit(serial_shift_data, bit_order_select);
    else if (bitcnt == 4'h0 && !edge_ev)
      sdo_q <= out_bit(serial_shift_data, bit_order_select);
  end

  // ----------------------------------------
  // Control registers and flags
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ctl0 <= CTL_RESET;
      ctl1 <= CTL_RESET;
      ctl2 <= CTL_RESET[7:2];
    end
    else
    begin
      if (wr_ctl0) ctl0 <= req.wdata;
      if (wr_ctl1) ctl1 <= req.wdata;
      if (wr_ctl2) ctl2 <= req.wdata[7:2];
    end
  end

  // Hardware set beats a software clear in the same cycle
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      transfer_done_flag <= 1'b0;
    else if (done_pulse)
      transfer_done_flag <= 1'b1;
    else if (wr_ctl2 && !req.wdata[CTL2_TRF_BIT])
      transfer_done_flag <= 1'b0;
  end

  // Flag only works when its option is fitted
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      write_collision_flag <= 1'b0;
    else if (wr_data && busy && opt_collision_bit)
      write_collision_flag <= 1'b1;
    else if (wr_ctl2 && !req.wdata[CTL2_WRITE_COLLISION_FLAG_BIT])
      write_collision_flag <= 1'b0;
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      rdata <= 8'h00;
    else if (!req.rd)
      rdata <= 8'h00;
    else
    begin
      unique case (req.addr)
        OFS_DATA: rdata <= serial_shift_data;
        OFS_CTL0: rdata <= ctl0;
        OFS_CTL1: rdata <= ctl1;
        OFS_CTL2: rdata <= {ctl2, write_collision_flag, transfer_done_flag};
        default:  rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------
  // Pin drivers and status outputs
  // ----------------------------------------
  // All enables drop unless the SPI function owns the pins
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      pins_o           <= '0;
      sel_hold         <= 1'b0;
      twowire_selected <= 1'b0;
      periph_prescale  <= CTL_RESET[2:0];
    end
    else
    begin
      pins_o.sck      <= sck_q;
      pins_o.sck_oe   <= engine_on && is_master;
      pins_o.sdo      <= sdo_q;
      pins_o.sdo_oe   <= engine_on && (is_master || slave_sel);
      // Release lags the final clock edge, so the slave still sees it selected
      sel_hold        <= (state == ST_RUN);
      pins_o.scs_n    <= !(state == ST_RUN || sel_hold);
      pins_o.scs_n_oe <= select_active && is_master;
      twowire_selected <= opt_serial_function && serial_unit_on &&
        (serial_mode_select == MODE_TWOWIRE);
      periph_prescale  <= ctl0[CTL0_PRE_LSB +: 3];
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_master_load;
    load_ok && is_master && engine_on && state == ST_IDLE;
  endsequence

  sequence s_half_div4;
    !div_tick ##1 div_tick;
  endsequence

  a_master_start:
    assert property (s_master_load |=> state == ST_RUN ##1 !pins_o.scs_n)
    else $error("master write did not start a transfer");

  a_done_sets:
    assert property (done_pulse |=> transfer_done_flag ##1
      (transfer_done_flag || $past(wr_ctl2)))
    else $error("done flag not set after transfer");

  a_collision_set:
    assert property (wr_data && busy && opt_collision_bit
      |=> write_collision_flag)
    else $error("collision flag not set on busy write");

  a_rate_div4:
    assert property (div_tick && state == ST_RUN && serial_mode_select == MODE_DIV4
      && bitcnt < 4'h4 |=> s_half_div4)
    else $error("divide by four rate wrong");

  a_sck_idle:
    assert property (state == ST_IDLE && is_master && engine_on
      ##1 state == ST_IDLE && $stable(idle_lvl) |-> sck_q == idle_lvl)
    else $error("clock not at base level while idle");

  a_gpio_off:
    assert property (!opt_serial_function |=> !pins_o.sck_oe && !pins_o.sdo_oe
      && !pins_o.scs_n_oe)
    else $error("pins driven without function option");

  a_select_role:
    assert property (!(opt_select_bit && select_pin_enable) |=> !pins_o.scs_n_oe)
    else $error("select pin driven without option and enable");

  a_slave_no_clk:
    assert property (is_slave |=> !pins_o.sck_oe)
    else $error("slave drives the clock");

  a_deselect_hold:
    assert property (is_slave && select_active && scs_s |=> bitcnt == 4'h0)
    else $error("deselected slave counted clock edges");

endmodule

/* shared/serial_pkg.sv */
package serial_pkg;

  // ----------------------------------------
  // Register offsets on the register port
  // ----------------------------------------
  localparam logic [7:0] OFS_DATA = 8'h00;  // Shift data register
  localparam logic [7:0] OFS_CTL0 = 8'h01;  // Enable, mode, prescaler
  localparam logic [7:0] OFS_CTL1 = 8'h02;  // Two-wire use only
  localparam logic [7:0] OFS_CTL2 = 8'h03;  // Edge, order, flags

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTL0_MODE_LSB = 5;  // Three-bit mode field
  localparam int CTL0_PRE_LSB  = 2;  // Three-bit peripheral prescaler
  localparam int CTL0_ON_BIT   = 1;  // Unit on/off
  localparam int CTL2_POL_BIT  = 5;  // Clock idle polarity
  localparam int CTL2_EDGE_BIT = 4;  // Clock active edge
  localparam int CTL2_MLS_BIT  = 3;  // Bit order, 1 = MSB first
  localparam int CTL2_SELECT_PIN_ENABLE_BIT = 2;  // Select pin enable
  localparam int CTL2_WRITE_COLLISION_FLAG_BIT = 1;  // Write collision flag
  localparam int CTL2_TRF_BIT  = 0;  // Transfer done flag

  // ----------------------------------------
  // Reset values and counts
  // ----------------------------------------
  localparam logic [7:0] CTL_RESET      = 8'h00;  // All control bits clear
  localparam logic [7:0] DATA_RESET     = 8'h00;  // Data clears to zero at reset
  localparam logic       SCK_IDLE_RESET = 1'b1;   // Polarity 0 idles high
  localparam logic [3:0] BYTE_BITS      = 4'h8;   // Bits per transfer

  // Half periods of the master clock in system cycles
  localparam logic [5:0] HALF_DIV2  = 6'h01;
  localparam logic [5:0] HALF_DIV4  = 6'h02;
  localparam logic [5:0] HALF_DIV16 = 6'h08;
  localparam logic [5:0] HALF_DIV64 = 6'h20;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [2:0] {
    MODE_DIV4    = 3'b000,
    MODE_DIV16   = 3'b001,
    MODE_DIV64   = 3'b010,
    MODE_DIV1    = 3'b011,
    MODE_DIV2    = 3'b100,
    MODE_SLAVE   = 3'b101,
    MODE_TWOWIRE = 3'b110,
    MODE_UNUSED  = 3'b111
  } serial_mode_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } link_state_e;

  typedef struct packed {
    logic [7:0] addr;   // Register offset
    logic [7:0] wdata;  // Write data
    logic       wr;     // Write strobe
    logic       rd;     // Read strobe
  } reg_req_s;

  typedef struct packed {
    logic sdi;    // Serial data in
    logic sck;    // Clock pin level
    logic scs_n;  // Select pin level
  } pins_in_s;

  typedef struct packed {
    logic sdo;
    logic sdo_oe;
    logic sck;
    logic sck_oe;
    logic scs_n;
    logic scs_n_oe;
  } pins_out_s;

  // Undivided clock cannot come from a flop, so it runs as /2
  function automatic logic [5:0] half_period(input serial_mode_e m);
    logic [5:0] h;
    h = HALF_DIV2;
    if (m == MODE_DIV4) h = HALF_DIV4;
    if (m == MODE_DIV16) h = HALF_DIV16;
    if (m == MODE_DIV64) h = HALF_DIV64;
    return h;
  endfunction

endpackage

/* hdl/serial_rate_divider.sv */
`timescale 1ns/1ps
module serial_rate_divider
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  // Control
  input  wire logic       run,
  input  wire logic [5:0] half_cycles,
  // Enable pulse
  output logic            tick
);

  // ----------------------------------------
  // Half-period counter
  // ----------------------------------------
  logic [5:0] cnt;  // Cycles since last tick

  // Restarts whenever the master goes idle, so each byte starts aligned
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt  <= 6'h00;
      tick <= 1'b0;
    end
    else if (!run)
    begin
      cnt  <= 6'h00;
      tick <= 1'b0;
    end
    else if (cnt >= half_cycles - 6'h01)
    begin
      cnt  <= 6'h00;
      tick <= 1'b1;
    end
    else
    begin
      cnt  <= cnt + 6'h01;
      tick <= 1'b0;
    end
  end

endmodule

/* verification/spi_peer_model.sv */
`timescale 1ns/1ps
// External SPI slave that follows the clock the device drives
module spi_peer_model
(
  // Bus lines
  input  wire logic       sck,       // Driven by the master only
  input  wire logic       scs_n,
  input  wire logic       sdo,
  output logic            sdi,
  // Setup from the bench
  input  wire logic       act_rise,  // Active edge is rising
  input  wire logic       msb,       // Bit order, 1 = MSB first
  input  wire logic [7:0] tx,
  // Result
  output logic [7:0]      rx,
  output logic [3:0]      cnt
);
  logic [2:0] idx;  // Next bit to send

  initial
  begin
    sdi = 1'b0;
    rx  = 8'h00;
    cnt = 4'h0;
  end

  // Select: load first bit before the first edge
  always @(negedge scs_n)
  begin
    cnt = 4'h0;
    sdi = msb ? tx[7] : tx[0];
  end

  // Released line shows the inverse, never a stale value
  always @(posedge scs_n)
    sdi = ~sdi;

  // Sample on the active edge, shift on the other
  always @(sck)
  begin
    if (!scs_n && sck == act_rise)
    begin
      rx  = msb ? {rx[6:0], sdo} : {sdo, rx[7:1]};
      cnt = cnt + 4'h1;
    end
    else if (!scs_n && cnt != 4'h0 && cnt < 4'h8)
    begin
      idx = msb ? 3'(4'h7 - cnt) : cnt[2:0];
      sdi = tx[idx];
    end
  end
endmodule

/* verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import serial_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic       clk_sys, rstn, opt_f, opt_s, opt_c;
  reg_req_s   req;
  logic [7:0] rdata, v, ptx, prx;
  pins_in_s   pins_i;
  pins_out_s  pins_o;
  logic       tw, m_sck, m_scs_n, m_sdi, use_p, act, msb, psdi;
  logic [2:0] pre;
  logic [3:0] pcnt;
  int         errors, check_count;

  // Wire levels; select line has a pull-up
  assign pins_i = {use_p ? psdi : m_sdi,
                   pins_o.sck_oe ? pins_o.sck : m_sck,
                   pins_o.scs_n_oe ? pins_o.scs_n : m_scs_n};

  serial_spi_port i_dut (.clk_sys(clk_sys), .rstn(rstn), .opt_serial_function(opt_f),
    .opt_select_bit(opt_s), .opt_collision_bit(opt_c), .req(req), .rdata(rdata),
    .pins_i(pins_i), .pins_o(pins_o), .twowire_selected(tw), .periph_prescale(pre));
  spi_peer_model i_peer (.sck(pins_i.sck), .scs_n(pins_i.scs_n | !use_p), .sdo(pins_o.sdo),
    .sdi(psdi), .act_rise(act), .msb(msb), .tx(ptx), .rx(prx), .cnt(pcnt));

  always #4 clk_sys = ~clk_sys;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [7:0] b(input logic x);
    return {7'h00, x};
  endfunction
  function automatic logic [7:0] c0(input serial_mode_e m);
    return {m, 5'b00010};  // Unit on
  endfunction
  function automatic logic [7:0] c2(input logic p, input logic e, input logic o, input logic s);
    return {2'b00, p, e, o, s, 2'b00};  // Flag bits 0 clear both flags
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  // Ends just past an edge so outputs have settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Bounded poll of the done flag
  task automatic wait_flag;
    int k;
    k = 0;
    v = 8'h00;
    while (v[0] !== 1'b1 && k < 600)
    begin
      rd(OFS_CTL2, v);
      k++;
    end
    chk(b(v[0]), 8'h01);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(OFS_CTL0, v);
    chk(v, CTL_RESET);
    rd(OFS_CTL2, v);
    chk(v, CTL_RESET);
    rd(OFS_DATA, v);
    chk(v, DATA_RESET);
    rd(8'h07, v);
    chk(v, 8'h00);
    wr(OFS_CTL1, 8'h5A);
    rd(OFS_CTL1, v);
    chk(v, 8'h5A);
    chk({5'h00, pins_o.sdo_oe, pins_o.sck_oe, pins_o.scs_n_oe}, 8'h00);
    $display("t_reset done");
  endtask

  // Function option off, unit off, two-wire mode
  task automatic t_opts;
    @(posedge clk_sys);
    opt_f <= 1'b0;
    wr(OFS_CTL2, c2(1'b0, 1'b0, 1'b1, 1'b1));
    wr(OFS_CTL0, c0(MODE_DIV16));
    wr(OFS_DATA, 8'h11);
    cyc(40);
    chk({5'h00, pins_o.sdo_oe, pins_o.sck_oe, pins_o.scs_n_oe}, 8'h00);
    rd(OFS_CTL2, v);
    chk(b(v[0]), 8'h00);
    @(posedge clk_sys);
    opt_f <= 1'b1;
    wr(OFS_CTL0, c0(MODE_DIV16) & 8'hFD);
    cyc(3);
    chk({5'h00, pins_o.sdo_oe, pins_o.sck_oe, pins_o.scs_n_oe}, 8'h00);
    wr(OFS_CTL0, {MODE_TWOWIRE, 5'b10110});
    cyc(3);
    chk(b(tw), 8'h01);
    chk(8'(pre), 8'h05);
    chk(b(pins_o.sck_oe), 8'h00);
    wr(OFS_CTL0, 8'h00);
    $display("t_opts done");
  endtask

  // Master clock half period for every rate code
  task automatic t_rate;
    serial_mode_e md[5];
    logic [5:0]   hf[5];
    int           i;
    int           n;
    logic         s;
    md = '{MODE_DIV4, MODE_DIV16, MODE_DIV64, MODE_DIV1, MODE_DIV2};
    hf = '{HALF_DIV4, HALF_DIV16, HALF_DIV64, HALF_DIV2, HALF_DIV2};
    for (i = 0; i < 5; i++)
    begin
      wr(OFS_CTL2, c2(1'b0, 1'b0, 1'b1, 1'b1));
      wr(OFS_CTL0, c0(md[i]));
      wr(OFS_DATA, 8'hC3);
      s = pins_o.sck;
      n = 0;
      while (pins_o.sck === s && n < 100)
      begin
        cyc(1);
        n++;
      end
      s = pins_o.sck;
      n = 0;
      while (pins_o.sck === s && n < 100)
      begin
        cyc(1);
        n++;
      end
      chk(8'(n), {2'b00, hf[i]});
      wait_flag;
      chk(8'(pcnt), 8'h08);
    end
    $display("t_rate done");
  endtask

  // Every polarity, edge and order combination
  task automatic t_xfer;
    int         i;
    logic [7:0] t;
    logic       p;
    logic       e;
    logic       m;
    for (i = 0; i < 8; i++)
    begin
      {p, e, m} = 3'(i);
      t = 8'hC5 - 8'(i);
      @(posedge clk_sys);
      act <= (p == e);
      msb <= m;
      ptx <= 8'h1E + 8'(i * 9);
      wr(OFS_CTL2, c2(p, e, m, 1'b1));
      wr(OFS_CTL0, c0(MODE_DIV16));
      cyc(3);
      chk(b(pins_o.sck), b(!p));
      chk(b(pins_o.sck_oe), 8'h01);
      wr(OFS_DATA, t);
      cyc(4);
      chk(b(pins_o.scs_n), 8'h00);
      chk(b(pins_o.scs_n_oe), 8'h01);
      wait_flag;
      chk(prx, t);
      chk(8'(pcnt), 8'h08);
      rd(OFS_DATA, v);
      chk(v, ptx);
    end
    $display("t_xfer done");
  endtask

  // Write while busy, with and without the collision option
  task automatic t_coll;
    int i;
    act <= 1'b1;
    for (i = 0; i < 2; i++)
    begin
      @(posedge clk_sys);
      opt_c <= (i == 0);
      wr(OFS_CTL2, c2(1'b0, 1'b0, 1'b1, 1'b1));
      wr(OFS_DATA, 8'h81);
      cyc(20);
      wr(OFS_DATA, 8'h18);
      rd(OFS_CTL2, v);
      chk(b(v[1]), b(i == 0));
      wait_flag;
      chk(prx, 8'h81);
      wr(OFS_CTL2, c2(1'b0, 1'b0, 1'b1, 1'b1));
      rd(OFS_CTL2, v);
      chk(v & 8'h03, 8'h00);
    end
    @(posedge clk_sys);
    opt_c <= 1'b1;
    $display("t_coll done");
  endtask

  // Select pin stays general I/O with its enable bit low
  task automatic t_select;
    wr(OFS_CTL2, c2(1'b0, 1'b0, 1'b1, 1'b0));
    wr(OFS_DATA, 8'h99);
    cyc(6);
    chk(b(pins_o.scs_n_oe), 8'h00);
    chk(b(pins_o.sck_oe), 8'h01);
    wait_flag;
    $display("t_select done");
  endtask

  // Bench as master; clocks while deselected must be ignored
  task automatic t_slave;
    int         k;
    logic [7:0] g;
    use_p <= 1'b0;
    wr(OFS_CTL2, c2(1'b0, 1'b0, 1'b1, 1'b1));
    wr(OFS_CTL0, c0(MODE_SLAVE));
    wr(OFS_DATA, 8'h96);
    cyc(3);
    chk(b(pins_o.sck_oe), 8'h00);
    for (k = 0; k < 9; k++)
    begin
      @(posedge clk_sys);
      m_sck <= k[0];
      repeat (5) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    m_scs_n <= 1'b0;
    m_sdi   <= 1'b0;
    cyc(6);
    chk(b(pins_o.sdo_oe), 8'h01);
    for (k = 7; k >= 0; k--)
    begin
      @(posedge clk_sys);
      m_sck <= 1'b0;
      m_sdi <= !(k[0] ^ k[1] ^ k[2]);
      repeat (6) @(posedge clk_sys);
      g[k] = pins_o.sdo;
      m_sck <= 1'b1;
      repeat (5) @(posedge clk_sys);
    end
    m_scs_n <= 1'b1;
    cyc(6);
    rd(OFS_DATA, v);
    chk(v, 8'h69);
    chk(g, 8'h96);
    rd(OFS_CTL2, v);
    chk(b(v[0]), 8'h01);
    $display("t_slave done");
  endtask

  task automatic finish_test;
    $display("Counts: errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial
  begin
    {clk_sys, rstn, m_sck, m_sdi, act, msb} = 6'b000111;
    {opt_f, opt_s, opt_c, m_scs_n, use_p} = 5'b11111;
    {req, ptx, errors, check_count} = '0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset;
    t_opts;
    t_rate;
    t_xfer;
    t_coll;
    t_select;
    t_slave;
    finish_test;
  end

  // Whole run needs well under a tenth of this span
  initial
  begin
    #400000;
    errors++;
    $display("Watchdog expired");
    finish_test;
  end
endmodule
